// [core/otl_logic.sv]
// Purpose: Blocking scheme and weak infeed decisions for overcurrent teleprotection.
// Assumes: Settings are static in operation; pickups arrive asynchronously.
// Notes:   All outputs are registered; timers run on a 1 ms tick.
`timescale 1ns/1ps
`default_nettype none
module otl_logic #(
    parameter int unsigned TICK_CYCLES = otl_pkg::TICK_CYCLES
) (
    input  wire logic               ref_clk_i,
    input  wire logic               arst_n_i,
    input  wire otl_pkg::otl_in_t   pins_i,
    input  wire logic [2:0]         scheme_select_i,
    input  wire logic [1:0]         weak_feed_output_select_i,
    input  wire logic               reverse_from_input_i,
    input  wire logic [1:0]         reverse_element_select_i,
    input  wire logic [7:0]         blocking_trip_delay_i,
    input  wire logic [7:0]         reverse_dropout_time_i,
    input  wire logic [7:0]         reversal_coordination_time_i,
    input  wire logic [7:0]         receive_safety_time_i,
    output var  otl_pkg::otl_out_t  outs_o
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        otl_pkg::otl_in_t  s1;
        otl_pkg::otl_in_t  s2;
        otl_pkg::otl_in_t  s3;
        otl_pkg::otl_in_t  in;
        logic [31:0]       pre;
        logic [7:0]        t_blk;
        logic [7:0]        t_rev;
        logic              rev_held;
        logic [7:0]        receive_safety_time;
        logic [7:0]        reverse_dropout_time;
        otl_pkg::otl_out_t out;
    } otl_state_t;

    otl_state_t st;
    otl_state_t next_st;

    // Clamp a millisecond setting to its legal maximum.
    function automatic logic [7:0] clamp_ms(input logic [7:0] v, input logic [7:0] mx);
        clamp_ms = (v > mx) ? mx : v;
    endfunction

    // Advance a timer on the tick while qualified, holding at the limit; clears when unqualified.
    function automatic logic [7:0] run_timer(input logic q, input logic tk, input logic [7:0] t,
                                             input logic [7:0] lim);
        if (!q) begin
            run_timer = 8'h00;
        end else if (tk && t < lim) begin
            run_timer = t + 8'h01;
        end else begin
            run_timer = t;
        end
    endfunction

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        logic        tick;
        logic        blk_sel;
        logic        rev_raw;
        logic        rev;
        logic        ov;
        logic        stop;
        logic        tx;
        logic        ov_q;
        logic        rx_wf;
        logic        rx_ok;
        logic        wf_echo_en;
        logic        wf_trip_en;
        logic        coord_ok;
        logic [7:0]  blk_lim;
        otl_pkg::otl_in_t chg;
        // Every local starts from a known value so no path leaves a latch.
        tick       = 1'b0;
        blk_sel    = 1'b0;
        rev_raw    = 1'b0;
        rev        = 1'b0;
        ov         = 1'b0;
        stop       = 1'b0;
        tx         = 1'b0;
        ov_q       = 1'b0;
        rx_wf      = 1'b0;
        rx_ok      = 1'b0;
        wf_echo_en = 1'b0;
        wf_trip_en = 1'b0;
        coord_ok   = 1'b0;
        blk_lim    = 8'h00;
        chg        = '0;
        next_st = st;
        next_st.s1 = pins_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        chg = ~(st.s2 ^ st.s3);
        next_st.in = (st.s2 & chg) | (st.in & ~chg);
        tick = (st.pre == 32'(TICK_CYCLES - 1));
        next_st.pre = tick ? 32'h0000_0000 : st.pre + 32'h0000_0001;

        blk_sel = (scheme_select_i == otl_pkg::OTL_BLOCKING);
        unique case (reverse_element_select_i)
            2'b00:   rev_raw = st.in.gnd_inst2_pickup;
            2'b01:   rev_raw = st.in.neg_inst2_pickup;
            default: rev_raw = st.in.gnd_inst2_pickup | st.in.neg_inst2_pickup;
        endcase
        if (reverse_from_input_i) begin
            rev_raw = st.in.reverse_pickup_input;
        end
        next_st.t_rev = run_timer(!rev_raw, tick, st.t_rev, clamp_ms(reverse_dropout_time_i, otl_pkg::COORD_MAX));
        if (rev_raw) begin
            next_st.rev_held = 1'b1;
        end else if (next_st.t_rev >= clamp_ms(reverse_dropout_time_i, otl_pkg::COORD_MAX)) begin
            next_st.rev_held = 1'b0;
        end
        rev = rev_raw | st.rev_held;
        ov  = st.in.overreach_pickup_input;

        stop = st.in.channel_disable_input | st.in.underreach_pickup;
        stop = stop | (ov & ~st.in.channel_receive_input & ~rev & ~st.in.channel_trip_block_input);
        tx = (rev & ~ov) | st.in.channel_trip_block_input;

        blk_lim = clamp_ms(blocking_trip_delay_i, otl_pkg::BLKDLY_MAX);
        next_st.t_blk = run_timer(blk_sel & ov, tick, st.t_blk, blk_lim);
        ov_q = blk_sel & ov & (st.t_blk >= blk_lim);

        rx_wf = st.in.channel_receive_input &
                ((scheme_select_i != otl_pkg::OTL_UNBLOCK) | st.in.guard_loss_input);
        next_st.receive_safety_time = run_timer(rx_wf, tick, st.receive_safety_time, clamp_ms(receive_safety_time_i, otl_pkg::SAFETY_MAX));
        rx_ok = rx_wf & (st.receive_safety_time >= clamp_ms(receive_safety_time_i, otl_pkg::SAFETY_MAX));
        wf_echo_en = (scheme_select_i != otl_pkg::OTL_BLOCKING) &&
                     (scheme_select_i != otl_pkg::OTL_NONE) &&
                     (weak_feed_output_select_i == otl_pkg::OTL_WF_ECHO ||
                      weak_feed_output_select_i == otl_pkg::OTL_WF_ECHO_TRIP);
        wf_trip_en = wf_echo_en && (weak_feed_output_select_i == otl_pkg::OTL_WF_ECHO_TRIP);
        next_st.reverse_dropout_time = run_timer(rx_ok & ~(rev & ov), tick, st.reverse_dropout_time,
                                    clamp_ms(reversal_coordination_time_i, otl_pkg::COORD_MAX));
        coord_ok = st.reverse_dropout_time >= clamp_ms(reversal_coordination_time_i, otl_pkg::COORD_MAX);

        next_st.out.echo_signal = wf_echo_en & rx_ok & ~rev_raw;
        next_st.out.weak_feed_trip = wf_trip_en & st.in.undervoltage & rx_ok & ~(rev & ov) & coord_ok;
        next_st.out.channel_stop_out = blk_sel & stop;
        next_st.out.channel_transmit_out = (blk_sel & tx & ~stop) | next_st.out.echo_signal;
        next_st.out.scheme_trip_out = ov_q & ~st.in.channel_receive_input & ~rev &
                                      ~st.in.channel_trip_block_input;
        next_st.out.elem2_reverse_force = blk_sel;
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Registered outputs.
    assign outs_o = st.out;
endmodule
`default_nettype wire

// [core/otl_pkg.sv]
// Purpose: Constants and types for the overcurrent teleprotection logic.
// Assumes: 100 MHz reference clock, 1 ms scheme time base.
// Notes:   Settings arrive as plain ports in milliseconds.
package otl_pkg;
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned TICK_MS      = 1;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    localparam int          TW           = 8;
    localparam logic [7:0] COORD_MAX    = 8'h32;
    localparam logic [7:0] COORD_DEF    = 8'h19;
    localparam logic [7:0] BLKDLY_MAX   = 8'hC8;
    localparam logic [7:0] BLKDLY_STEP  = 8'h0A;
    localparam logic [7:0] BLKDLY_DEF   = 8'h32;
    localparam logic [7:0] SAFETY_MAX   = 8'h32;
    localparam logic [7:0] SAFETY_DEF   = 8'h00;

    typedef enum logic [2:0] {
        OTL_NONE     = 3'b000,
        OTL_PUTT     = 3'b001,
        OTL_DTT      = 3'b010,
        OTL_POTT     = 3'b011,
        OTL_UNBLOCK  = 3'b100,
        OTL_BLOCKING = 3'b101
    } otl_scheme_t;

    typedef enum logic [1:0] {
        OTL_WF_NONE      = 2'b00,
        OTL_WF_ECHO      = 2'b01,
        OTL_WF_ECHO_TRIP = 2'b10
    } otl_wf_t;

    typedef struct packed {
        logic overreach_pickup_input;
        logic reverse_pickup_input;
        logic underreach_pickup;
        logic gnd_inst2_pickup;
        logic neg_inst2_pickup;
        logic channel_receive_input;
        logic guard_loss_input;
        logic channel_disable_input;
        logic channel_trip_block_input;
        logic undervoltage;
    } otl_in_t;

    typedef struct packed {
        logic channel_transmit_out;
        logic channel_stop_out;
        logic scheme_trip_out;
        logic echo_signal;
        logic weak_feed_trip;
        logic elem2_reverse_force;
    } otl_out_t;
endpackage

// [bench/otl_props.sv]
// Purpose: Assertions on the teleprotection outputs.
// Assumes: Inputs held for 8 clocks have reached the outputs.
// Notes:   Output bits 5..0 are transmit, stop, trip, echo, weak trip, force.
`timescale 1ns/1ps
`default_nettype none
module otl_props (
    input wire logic              ref_clk_i,
    input wire logic              arst_n_i,
    input wire otl_pkg::otl_in_t  pins_i,
    input wire logic [2:0]        scheme_select_i,
    input wire logic [1:0]        weak_feed_output_select_i,
    input wire otl_pkg::otl_out_t outs_o
);
    // ----
    // Checks
    // ----
    // Blocking scheme selected; settled inputs are judged after 8 clocks.
    logic blk;
    assign blk = scheme_select_i == 3'h5;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    stop_clears_tx_a: assert property (outs_o[4] |-> !outs_o[5])
        else $error("Transmit raised during channel stop.");
    off_scheme_quiet_a: assert property ((!blk)[*8] |-> !outs_o[4] && !outs_o[3])
        else $error("Blocking outputs active outside the blocking scheme.");
    elem2_force_a: assert property ($stable(scheme_select_i)[*8] |-> outs_o[0] == blk)
        else $error("Element 2 force does not follow the scheme.");
    rx_blocks_trip_a: assert property ((blk && pins_i.channel_receive_input)[*8] |-> !outs_o[3])
        else $error("Trip while a blocking signal is received.");
    block_kills_trip_a: assert property (pins_i.channel_trip_block_input[*8] |-> !outs_o[3])
        else $error("Trip while the trip block input is active.");
    disable_stops_a: assert property ((blk && (pins_i.channel_disable_input || pins_i.underreach_pickup))[*8]
        |-> outs_o[4])
        else $error("No channel stop on disable or underreach.");
    echo_needs_sel_a: assert property ((weak_feed_output_select_i == 2'h0)[*8] |-> !outs_o[2])
        else $error("Echo with weak infeed output off.");
    wtrip_needs_sel_a: assert property ((weak_feed_output_select_i != 2'h2)[*8] |-> !outs_o[1])
        else $error("Weak infeed trip without the trip option.");
endmodule
bind otl_logic otl_props props_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pins_i(pins_i),
    .scheme_select_i(scheme_select_i), .weak_feed_output_select_i(weak_feed_output_select_i), .outs_o(outs_o));
`default_nettype wire

// [bench/otl_carrier.sv]
// Purpose: Carrier equipment model at the line end.
// Assumes: The remote blocking key is commanded by the bench.
// Notes:   Registered, so it answers one clock after its inputs.
`timescale 1ns/1ps
`default_nettype none
module otl_carrier (
    input  wire logic ref_clk_i,
    input  wire logic tx_i,
    input  wire logic stop_i,
    input  wire logic remote_i,
    output logic      rx_o,
    output logic      line_o
);
    // ----
    // Channel
    // ----
    // stop halts sending
    always_ff @(posedge ref_clk_i) begin
        line_o <= tx_i && !stop_i;
        rx_o   <= remote_i;
    end
endmodule
`default_nettype wire

// [bench/otl_logic_bench.sv]
// Purpose: Self-checking bench for the teleprotection logic.
// Assumes: A tick of 10 clocks, so 1 ms is 10 cycles.
// Notes:   Inputs move 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module otl_logic_bench;
    // ----
    // Stimulus and wiring
    // ----
    logic              ref_clk_i   = 1'h0;
    logic              arst_n_i    = 1'h0;
    logic              remote      = 1'h0;
    logic [2:0]        scheme      = 3'h5;
    logic [1:0]        wf          = 2'h0;
    logic [7:0]        dly         = 8'h00;
    logic [7:0]        drop        = 8'h00;
    logic [7:0]        safe        = 8'h00;
    logic              rx;
    logic              line;
    otl_pkg::otl_in_t  pins        = '0;
    otl_pkg::otl_in_t  pins_w;
    otl_pkg::otl_out_t outs;
    int                errors      = 0;
    int                check_count = 0;
    // Clock, and the received channel merged into the pins.
    always #5 ref_clk_i = ~ref_clk_i;
    always_comb begin
        pins_w = pins;
        pins_w.channel_receive_input = rx;
    end
    otl_carrier far_u (.ref_clk_i(ref_clk_i), .tx_i(outs.channel_transmit_out),
        .stop_i(outs.channel_stop_out), .remote_i(remote), .rx_o(rx), .line_o(line));
    otl_logic #(.TICK_CYCLES(10)) dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pins_i(pins_w),
        .scheme_select_i(scheme), .weak_feed_output_select_i(wf), .reverse_from_input_i(1'h1),
        .reverse_element_select_i(2'h0), .blocking_trip_delay_i(dly), .reverse_dropout_time_i(drop),
        .reversal_coordination_time_i(8'h00), .receive_safety_time_i(safe), .outs_o(outs));
    // ----
    // Helpers
    // ----
    // Verdict and end of run.
    task automatic stop_test();
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    // Waits for an output bit to rise within hi cycles, and not before lo.
    task automatic rise(input string what, input int b, input int lo, input int hi);
        int n;
        n = 0;
        while (outs[b] !== 1'h1 && n < hi) begin
            cyc(1);
            n++;
        end
        chk(what, outs[b], 1'h1);
        chk(what, n >= lo, 1'h1);
        if (outs[b] !== 1'h1) stop_test();
    endtask
    // ----
    // Scenarios
    // ----
    // Transmit, stop and trip block in the blocking scheme.
    task automatic t_block();
        pins.reverse_pickup_input = 1'h1;
        rise("transmit", 5, 0, 12);
        chk("elem2 force", outs[0], 1'h1);
        pins.channel_disable_input = 1'h1;
        rise("stop", 4, 0, 12);
        chk("transmit off", outs[5], 1'h0);
        cyc(1);
        chk("carrier line", line, 1'h0);
        pins = '0;
        cyc(12);
        pins.underreach_pickup = 1'h1;
        rise("stop ur", 4, 0, 12);
        pins = '0;
        pins.channel_trip_block_input = 1'h1;
        rise("transmit tb", 5, 0, 12);
        pins.overreach_pickup_input = 1'h1;
        cyc(60);
        chk("trip tb", outs[3], 1'h0);
        pins = '0;
        cyc(12);
    endtask
    // Delayed trip, blocking by receive and reverse, reverse hold.
    task automatic t_trip();
        dly = 8'h03;
        pins.overreach_pickup_input = 1'h1;
        rise("stop ov", 4, 0, 12);
        rise("trip", 3, 12, 40);
        remote = 1'h1;
        cyc(12);
        chk("trip rx", outs[3], 1'h0);
        remote = 1'h0;
        dly = 8'h00;
        drop = 8'h02;
        pins.reverse_pickup_input = 1'h1;
        cyc(12);
        chk("trip rv", outs[3], 1'h0);
        pins.reverse_pickup_input = 1'h0;
        rise("trip hold", 3, 8, 40);
        pins = '0;
        drop = 8'h00;
        cyc(12);
    endtask
    // Scheme off, then echo and weak infeed trip beside permissive schemes.
    task automatic t_weak();
        scheme = 3'h0;
        pins.overreach_pickup_input = 1'h1;
        cyc(12);
        chk("stop off", outs[4], 1'h0);
        pins = '0;
        scheme = 3'h3;
        wf = 2'h1;
        safe = 8'h02;
        cyc(10);
        remote = 1'h1;
        rise("echo", 2, 8, 35);
        chk("echo transmit", outs[5], 1'h1);
        pins.undervoltage = 1'h1;
        cyc(10);
        chk("no weak trip", outs[1], 1'h0);
        wf = 2'h2;
        rise("weak trip", 1, 0, 15);
        chk("echo kept", outs[2], 1'h1);
        pins.reverse_pickup_input = 1'h1;
        cyc(10);
        chk("echo rv", outs[2], 1'h0);
        pins = '0;
        scheme = 3'h4;
        cyc(30);
        chk("echo no guard", outs[2], 1'h0);
        pins.guard_loss_input = 1'h1;
        rise("echo guard", 2, 0, 35);
        remote = 1'h0;
        pins = '0;
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        cyc(3);
        chk("outs in reset", |outs, 1'h0);
        arst_n_i = 1'h1;
        cyc(2);
        t_block();
        t_trip();
        t_weak();
        stop_test();
    end
endmodule
`default_nettype wire
